// ---- dv/mmat_host_model.sv ----
/*
  Host on the two-wire management link, reduced to command-byte and STOP events.
  Assumes the link clock runs freely and answers come one link cycle after a strobe.
*/
`timescale 1ns/1ps
module mmat_host_model (
  // Link clock and answers.
  input wire logic linkClk,
  input wire logic linkAck,
  input wire logic linkNack,
  // Requests toward the module.
  output logic linkAddrStrobe,
  output logic linkAddrRead,
  output logic linkStopStrobe,
  output logic [2:0] linkWriteKind
);
  // Idle link; qualifiers carry garbage so nothing leans on stale values.
  initial begin
    linkAddrStrobe = 1'h0;
    linkAddrRead = 1'h1;
    linkStopStrobe = 1'h0;
    linkWriteKind = 3'h7;
  end

  // Send a command byte and report whether it was acknowledged.
  task automatic addr(input logic rd, output logic took);
    @(posedge linkClk) linkAddrStrobe <= 1'h1;
    linkAddrRead <= rd;
    @(posedge linkClk) linkAddrStrobe <= 1'h0;
    linkAddrRead <= !rd;
    took = 1'h0;
    repeat (3) begin
      @(posedge linkClk);
      took = took | (linkAck === 1'h1);
    end
  endtask

  // End an accepted write with a STOP of the given kind.
  task automatic stop(input logic [2:0] kind);
    @(posedge linkClk) linkStopStrobe <= 1'h1;
    linkWriteKind <= kind;
    @(posedge linkClk) linkStopStrobe <= 1'h0;
    linkWriteKind <= ~kind;
  endtask

  // Retry instead of waiting out a hold-off.
  task automatic poll(input logic rd, input int tries, output logic took);
    took = 1'h0;
    for (int i = 0; i < tries && !took; i++) begin
      addr(rd, took);
    end
  endtask
endmodule

// ---- dv/mmat_top_checker.sv ----
/*
  Checker for the access timing supervisor: link answers, hold-off, read and dependent limits,
  host reset qualification. Assumes it is bound into mmat_top and sees only its ports.
*/
`timescale 1ns/1ps
module mmat_top_checker #(
  parameter int MS_CYCLES = 10,
  parameter int READ_VAR_CYCLES = 20,
  parameter int FG_DEFAULT_MS = 80
) (
  // Clocks and resets.
  input wire logic sys_clk,
  input wire logic linkClk,
  input wire logic reset_n,
  input wire logic hostReset_n,
  // Link side.
  input wire logic linkAddrStrobe,
  input wire logic linkAck,
  input wire logic linkNack,
  // Core side.
  input wire logic coreReady,
  input wire logic [12:0] fgBusyLimitMs,
  input wire logic fgLimitAdvertised,
  input wire logic coreResetReq,
  input wire logic holdOffActive,
  input wire logic opStart,
  input wire logic [2:0] opKind,
  input wire logic opDone,
  input wire logic depStart,
  input wire logic [2:0] depKind,
  input wire logic depDone,
  input wire logic readReq,
  input wire logic readDone,
  input wire logic depFault,
  input wire logic readFault
);
  localparam int READ_LIM = READ_VAR_CYCLES;
  localparam int DEP_LIM = 10 * MS_CYCLES + 2;
  logic inHold, depPend;
  logic [7:0] lowCyc, lastLow;
  int holdCyc, depCyc, limMs;

  // Limit per kind; the foreground one follows the advertised value when it is enabled.
  always_comb begin
    case (opKind)
      3'h1, 3'h3: limMs = 80;
      3'h4: limMs = fgLimitAdvertised ? int'(fgBusyLimitMs) : FG_DEFAULT_MS;
      default: limMs = 10;
    endcase
  end

  // Open hold-offs, pending dependent updates and host reset pulse length, one cycle late on purpose.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      inHold <= 1'h0;
      depPend <= 1'h0;
      holdCyc <= 0;
      depCyc <= 0;
      lowCyc <= 8'h00;
      lastLow <= 8'h00;
    end else begin
      inHold <= opStart || (inHold && holdOffActive);
      holdCyc <= inHold ? holdCyc + 1 : 0;
      depPend <= depStart || (depPend && !depDone && !depFault);
      depCyc <= depStart ? 0 : (depPend ? depCyc + 1 : 0);
      lowCyc <= hostReset_n ? 8'h00 : lowCyc + {7'h00, lowCyc != 8'hFF};
      if (hostReset_n && lowCyc != 8'h00) begin
        lastLow <= lowCyc;
      end
    end
  end

  chk_answer_once: assert property (
    @(posedge linkClk) disable iff (!reset_n) linkAddrStrobe |=> (linkAck ^ linkNack))
    else $error("command byte not answered exactly once");
  chk_hold_nack: assert property (
    @(posedge linkClk) disable iff (!reset_n) linkAddrStrobe && holdOffActive && $past(holdOffActive, 3) |=> !linkAck)
    else $error("access accepted during hold-off");
  chk_hold_start: assert property (
    @(posedge sys_clk) disable iff (!reset_n) opStart |-> holdOffActive && opKind <= 3'h4)
    else $error("operation started without hold-off");
  chk_hold_end: assert property (
    @(posedge sys_clk) disable iff (!reset_n) inHold && holdOffActive && opDone |=> !holdOffActive)
    else $error("hold-off not ended by completion");
  chk_hold_bound: assert property (
    @(posedge sys_clk) disable iff (!reset_n) inHold |-> holdCyc <= limMs * MS_CYCLES + 3)
    else $error("hold-off outlasted its limit");
  chk_read_bound: assert property (
    @(posedge sys_clk) disable iff (!reset_n) readReq |-> ##[1:READ_LIM] (readDone || readFault))
    else $error("read delay not bounded");
  chk_init_exit: assert property (
    @(posedge sys_clk) disable iff (!reset_n) $rose(coreReady) && !inHold && hostReset_n |-> ##[1:3] !holdOffActive)
    else $error("manageability not reached");
  chk_dep_start: assert property (
    @(posedge sys_clk) disable iff (!reset_n) depStart |-> !holdOffActive && (depKind == 3'h5 || depKind == 3'h6))
    else $error("dependent update refused access or bad kind");
  chk_dep_bound: assert property (
    @(posedge sys_clk) disable iff (!reset_n) depPend |-> depCyc <= DEP_LIM)
    else $error("dependent update outlasted its limit");
  chk_rst_qualify: assert property (
    @(posedge sys_clk) disable iff (!reset_n) coreResetReq |-> lastLow >= 8'h63 && $past(hostReset_n, 6) == 1'h0)
    else $error("reset request without a qualified pulse");

  cov_hold: cover property (@(posedge sys_clk) disable iff (!reset_n) opStart);
  cov_dep: cover property (@(posedge sys_clk) disable iff (!reset_n) depStart);
  cov_read_fault: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(readFault));
  cov_host_reset: cover property (@(posedge sys_clk) disable iff (!reset_n) coreResetReq);
endmodule

bind mmat_top mmat_top_checker #(
  .MS_CYCLES(MS_CYCLES), .READ_VAR_CYCLES(READ_VAR_CYCLES), .FG_DEFAULT_MS(FG_DEFAULT_MS)
) u_mmat_top_checker (
  .sys_clk, .linkClk, .reset_n, .hostReset_n, .linkAddrStrobe, .linkAck, .linkNack, .coreReady,
  .fgBusyLimitMs, .fgLimitAdvertised, .coreResetReq, .holdOffActive, .opStart, .opKind, .opDone,
  .depStart, .depKind, .depDone, .readReq, .readDone, .depFault, .readFault
);

// ---- dv/test_mmat_top.sv ----
/*
  Testbench for the access timing supervisor: init, reads, hold-offs, dependent updates, host reset.
  Assumes the host model drives the link; the bench plays the core at the system clock.
*/
`timescale 1ns/1ps
module test_mmat_top;
  logic sys_clk = 1'h0;
  logic linkClk = 1'h0;
  logic reset_n, hostReset_n, coreReady, lowPowerExit, fgLimitAdvertised, opDone, depDone, readDone, took;
  logic [12:0] fgBusyLimitMs;
  logic linkAddrStrobe, linkAddrRead, linkStopStrobe, linkAck, linkNack, linkStretch;
  logic [2:0] linkWriteKind, opKind, depKind;
  logic coreResetReq, lowPowerState, holdOffActive, opStart, depStart, readReq;
  logic initFault, holdOffFault, depFault, readFault;
  int errTotal = 0;
  int nCompared = 0;
  int cycles = 0;
  int at;

  // Rising link edges never meet a system rising edge, so crossings see real skew.
  always #50 sys_clk = ~sys_clk;
  always #3 linkClk = ~linkClk;

  mmat_top #(.MS_CYCLES(10), .READ_VAR_CYCLES(20), .FG_DEFAULT_MS(80)) u_mmat_top (
    .sys_clk, .reset_n, .hostReset_n, .linkClk, .linkAddrStrobe, .linkAddrRead, .linkStopStrobe,
    .linkWriteKind, .linkAck, .linkNack, .linkStretch, .coreReady, .lowPowerExit, .fgBusyLimitMs,
    .fgLimitAdvertised, .coreResetReq, .lowPowerState, .holdOffActive, .opStart, .opKind, .opDone,
    .depStart, .depKind, .depDone, .readReq, .readDone, .initFault, .holdOffFault, .depFault, .readFault
  );
  mmat_host_model u_mmat_host_model (
    .linkClk, .linkAck, .linkNack, .linkAddrStrobe, .linkAddrRead, .linkStopStrobe, .linkWriteKind
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errTotal++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Pulse a core completion input for one system cycle.
  task automatic pulse(input int which);
    @(posedge sys_clk) opDone <= (which == 0);
    depDone <= (which == 1);
    readDone <= (which == 2);
    @(posedge sys_clk) {opDone, depDone, readDone} <= 3'h0;
  endtask

  // Read: stretch held until the core delivers, released at the limit otherwise.
  task automatic t_read(input logic deliver);
    u_mmat_host_model.addr(1'h1, took);
    check(took, 1'h1);
    check(linkStretch, 1'h1);
    for (int i = 0; i < 20 && readReq !== 1'h1; i++) @(posedge sys_clk);
    if (deliver) pulse(2);
    cyc(deliver ? 3 : 25);
    check(readFault, !deliver);
    check(linkStretch, 1'h0);
  endtask

  // Each hold-off kind refuses access until the core reports completion.
  task automatic t_hold();
    for (int k = 0; k < 5; k++) begin
      u_mmat_host_model.stop(k[2:0]);
      for (int i = 0; i < 10 && opStart !== 1'h1; i++) @(posedge sys_clk);
      check(opKind, k[2:0]);
      cyc(2);
      u_mmat_host_model.addr(1'h0, took);
      check(took, 1'h0);
      pulse(0);
      u_mmat_host_model.poll(1'h0, 20, took);
      check(took, 1'h1);
    end
  endtask

  // Dependent updates never hold off access and are timed out when the core stalls.
  task automatic t_dep(input logic [2:0] kind, input logic deliver);
    u_mmat_host_model.stop(kind);
    for (int i = 0; i < 10 && depStart !== 1'h1; i++) @(posedge sys_clk);
    check(depKind, kind);
    cyc(1);
    u_mmat_host_model.addr(1'h0, took);
    check(took, 1'h1);
    if (deliver) pulse(1);
    cyc(deliver ? 2 : 110);
    check(depFault, !deliver);
  endtask

  // Host reset pin low for len cycles; records the cycle of the reset request after release.
  task automatic t_host(input int len, input logic ready);
    at = -1;
    @(posedge sys_clk) hostReset_n <= 1'h0;
    coreReady <= ready;
    cyc(len);
    hostReset_n <= 1'h1;
    for (int i = 1; i <= 8; i++) begin
      @(posedge sys_clk);
      if (coreResetReq === 1'h1 && at < 0) at = i;
    end
  endtask

  // Cut a hang short.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      tally_and_finish();
    end
  end

  initial begin
    {reset_n, coreReady, lowPowerExit, fgLimitAdvertised, opDone, depDone, readDone} = 7'h00;
    hostReset_n = 1'h1;
    fgBusyLimitMs = 13'h0003;
    cyc(4);
    reset_n <= 1'h1;
    cyc(2);
    check({holdOffActive, lowPowerState}, 2'h3);
    u_mmat_host_model.addr(1'h0, took);
    check(took, 1'h0);
    @(posedge sys_clk) coreReady <= 1'h1;
    cyc(3);
    check(holdOffActive, 1'h0);
    @(posedge sys_clk) lowPowerExit <= 1'h1;
    @(posedge sys_clk) lowPowerExit <= 1'h0;
    cyc(2);
    check(lowPowerState, 1'h0);
    t_read(1'h1);
    t_hold();
    t_dep(3'h5, 1'h1);
    t_host(50, 1'h1);
    check(at < 0, 1'h1);
    t_host(120, 1'h0);
    check(at >= 2 && at <= 5, 1'h1);
    check(holdOffActive, 1'h1);
    @(posedge sys_clk) coreReady <= 1'h1;
    cyc(3);
    check(holdOffActive, 1'h0);
    @(posedge sys_clk) fgLimitAdvertised <= 1'h1;
    u_mmat_host_model.stop(3'h4);
    cyc(50);
    check({initFault, holdOffFault, holdOffActive}, 3'h2);
    t_dep(3'h6, 1'h0);
    t_read(1'h0);
    tally_and_finish();
  end
endmodule

// ---- src/mmat_defines.svh ----
/*
  Timing and field constants for the management access timing supervisor.
  Assumes the system clock rate below; derived cycle counts follow from it.
*/
`ifndef MMAT_DEFINES_SVH
`define MMAT_DEFINES_SVH

`define MMAT_CLK_HZ 10000000
`define MMAT_RESET_MIN_US 10
`define MMAT_RESET_MIN_CYC ((`MMAT_RESET_MIN_US * `MMAT_CLK_HZ + 999999) / 1000000)
`define MMAT_MS_CYC (`MMAT_CLK_HZ / 1000)
`define MMAT_READ_VAR_US 500
`define MMAT_READ_VAR_CYC ((`MMAT_READ_VAR_US * (`MMAT_CLK_HZ / 1000)) / 1000)
`define MMAT_INIT_MAX_MS 2000
`define MMAT_VOL_MS 10
`define MMAT_NV_MS 80
`define MMAT_PAGE_MS 10
`define MMAT_CAPT_MS 80
`define MMAT_FG_DEF_MS 80
`define MMAT_FG_MAX_MS 4960
`define MMAT_DEP_MS 10
`define MMAT_MS_W 13
`define MMAT_CNT_W 16
`define MMAT_KIND_W 3

`endif

// ---- src/mmat_link.sv ----
/*
  Link-side front end of the management access timing supervisor, on the link clock.
  Assumes a two-wire front end that strobes command-byte receipt and STOPs of accepted writes,
  and a supervisor on another clock that answers the toggles below.
*/
`timescale 1ns/1ps
`include "mmat_defines.svh"

module mmat_link (
  // Link clock and reset.
  input wire logic linkClk,
  input wire logic reset_n,
  // Events from the two-wire front end.
  input wire logic linkAddrStrobe,
  input wire logic linkAddrRead,
  input wire logic linkStopStrobe,
  input wire logic [`MMAT_KIND_W-1:0] linkWriteKind,
  // Answers to the front end.
  output logic linkAck,
  output logic linkNack,
  output logic linkStretch,
  // Crossing from the system domain.
  input wire logic holdOff,
  input wire logic stopAckToggle,
  input wire logic readDoneToggle,
  // Crossing to the system domain.
  output logic stopToggle,
  output logic [`MMAT_KIND_W-1:0] stopKind,
  output logic readReqToggle
);

  logic holdS1, holdS2, ackS1, ackS2, doneS1, doneS2, doneSeen;
  logic next_holdS1, next_holdS2, next_ackS1, next_ackS2, next_doneS1, next_doneS2, next_doneSeen;
  logic next_linkAck, next_linkNack, next_linkStretch, next_stopToggle, next_readReqToggle;
  logic [`MMAT_KIND_W-1:0] next_stopKind;
  logic stopPending;

  // A STOP is pending until the supervisor has seen it; its hold-off may not be visible yet.
  assign stopPending = stopToggle ^ ackS2;

  // Synchronisers, accept or refuse decision and read stretching.
  always_comb begin
    next_holdS1 = holdOff;
    next_holdS2 = holdS1;
    next_ackS1 = stopAckToggle;
    next_ackS2 = ackS1;
    next_doneS1 = readDoneToggle;
    next_doneS2 = doneS1;
    next_doneSeen = doneSeen;
    next_linkAck = 1'b0;
    next_linkNack = 1'b0;
    next_linkStretch = linkStretch;
    next_stopToggle = stopToggle;
    next_stopKind = stopKind;
    next_readReqToggle = readReqToggle;
    if (doneS2 != doneSeen) begin
      next_doneSeen = doneS2;
      next_linkStretch = 1'b0; // Data is ready or the read limit has run out; the clock is let go.
    end
    if (linkStopStrobe && !stopPending) begin
      next_stopToggle = ~stopToggle; // Hold-off time starts at this STOP.
      next_stopKind = linkWriteKind;
    end
    if (linkAddrStrobe) begin
      if (holdS2 || stopPending || linkStretch) begin
        next_linkNack = 1'b1; // Refused while a hold-off runs.
      end else begin
        next_linkAck = 1'b1; // Accepted only when no hold-off, pending STOP or stretch is outstanding.
        if (linkAddrRead) begin
          next_linkStretch = 1'b1; // Stretch while the core fetches.
          next_readReqToggle = ~readReqToggle;
        end
      end
    end
  end

  // Link-side registers.
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      holdS1 <= 1'b1;
      holdS2 <= 1'b1;
      ackS1 <= 1'b0;
      ackS2 <= 1'b0;
      doneS1 <= 1'b0;
      doneS2 <= 1'b0;
      doneSeen <= 1'b0;
      linkAck <= 1'b0;
      linkNack <= 1'b0;
      linkStretch <= 1'b0;
      stopToggle <= 1'b0;
      stopKind <= mmat_pkg::MMAT_KIND_NONE;
      readReqToggle <= 1'b0;
    end else begin
      holdS1 <= next_holdS1;
      holdS2 <= next_holdS2;
      ackS1 <= next_ackS1;
      ackS2 <= next_ackS2;
      doneS1 <= next_doneS1;
      doneS2 <= next_doneS2;
      doneSeen <= next_doneSeen;
      linkAck <= next_linkAck;
      linkNack <= next_linkNack;
      linkStretch <= next_linkStretch;
      stopToggle <= next_stopToggle;
      stopKind <= next_stopKind;
      readReqToggle <= next_readReqToggle;
    end
  end

endmodule

// ---- src/mmat_pkg.sv ----
/*
  Types shared by the supervisor and its link-side front end.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mmat_pkg;

  // Supervisor states, one-hot.
  typedef enum logic [2:0] {
    MMAT_ST_INIT = 3'h1,
    MMAT_ST_IDLE = 3'h2,
    MMAT_ST_HOLD = 3'h4
  } mmat_state_t;

  // Kind of write that ended with a bus STOP.
  typedef enum logic [2:0] {
    MMAT_KIND_VOLATILE = 3'h0,
    MMAT_KIND_PERSIST = 3'h1,
    MMAT_KIND_PAGE = 3'h2,
    MMAT_KIND_CAPTURE = 3'h3,
    MMAT_KIND_FOREGROUND = 3'h4,
    MMAT_KIND_DIAG = 3'h5,
    MMAT_KIND_FREEZE = 3'h6,
    MMAT_KIND_NONE = 3'h7
  } mmat_kind_t;

endpackage

// ---- src/mmat_top.sv ----
/*
  Management access timing supervisor: reset pulse qualification, time to manageability,
  read stretch limit, access hold-off periods and dependent-register latency watch.
  Assumes a core that reports completion of each operation, and a two-wire front end on the link clock.
*/
`timescale 1ns/1ps
`include "mmat_defines.svh"

module mmat_top #(
  parameter int MS_CYCLES = `MMAT_MS_CYC,
  parameter int READ_VAR_CYCLES = `MMAT_READ_VAR_CYC,
  parameter int FG_DEFAULT_MS = `MMAT_FG_DEF_MS
) (
  // System clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Module reset pin from the host, active low, asynchronous.
  input wire logic hostReset_n,
  // Two-wire front end on the link clock.
  input wire logic linkClk,
  input wire logic linkAddrStrobe,
  input wire logic linkAddrRead,
  input wire logic linkStopStrobe,
  input wire logic [`MMAT_KIND_W-1:0] linkWriteKind,
  output logic linkAck,
  output logic linkNack,
  output logic linkStretch,
  // Core control.
  input wire logic coreReady,
  input wire logic lowPowerExit,
  input wire logic [`MMAT_MS_W-1:0] fgBusyLimitMs,
  input wire logic fgLimitAdvertised,
  output logic coreResetReq,
  output logic lowPowerState,
  // Hold-off operations.
  output logic holdOffActive,
  output logic opStart,
  output logic [`MMAT_KIND_W-1:0] opKind,
  input wire logic opDone,
  // Dependent-register updates.
  output logic depStart,
  output logic [`MMAT_KIND_W-1:0] depKind,
  input wire logic depDone,
  // Read fetch.
  output logic readReq,
  input wire logic readDone,
  // Sticky faults.
  output logic initFault,
  output logic holdOffFault,
  output logic depFault,
  output logic readFault
);

  logic stopToggle, readReqToggle, stopAckToggle, readDoneToggle, msTick;
  logic [`MMAT_KIND_W-1:0] stopKind;

  // Link-side front end; all traffic with it crosses by synchronised toggles and levels, except stopKind, read unsynchronised once its toggle arrives.
  mmat_link u_mmat_link (
    .linkClk(linkClk),
    .reset_n(reset_n),
    .linkAddrStrobe(linkAddrStrobe),
    .linkAddrRead(linkAddrRead),
    .linkStopStrobe(linkStopStrobe),
    .linkWriteKind(linkWriteKind),
    .linkAck(linkAck),
    .linkNack(linkNack),
    .linkStretch(linkStretch),
    .holdOff(holdOffActive),
    .stopAckToggle(stopAckToggle),
    .readDoneToggle(readDoneToggle),
    .stopToggle(stopToggle),
    .stopKind(stopKind),
    .readReqToggle(readReqToggle)
  );

  // Saturating millisecond count.
  function automatic logic [`MMAT_MS_W-1:0] incSat(input logic [`MMAT_MS_W-1:0] v);
    incSat = (v == {`MMAT_MS_W{1'b1}}) ? v : v + `MMAT_MS_W'(1);
  endfunction

  // Longest hold-off for each kind of write.
  function automatic logic [`MMAT_MS_W-1:0] holdLimitFor(input logic [`MMAT_KIND_W-1:0] k,
                                                       input logic [`MMAT_MS_W-1:0] fg);
    case (k)
      mmat_pkg::MMAT_KIND_PERSIST: holdLimitFor = `MMAT_MS_W'(`MMAT_NV_MS);
      mmat_pkg::MMAT_KIND_PAGE: holdLimitFor = `MMAT_MS_W'(`MMAT_PAGE_MS);
      mmat_pkg::MMAT_KIND_CAPTURE: holdLimitFor = `MMAT_MS_W'(`MMAT_CAPT_MS);
      mmat_pkg::MMAT_KIND_FOREGROUND: holdLimitFor = fg;
      default: holdLimitFor = `MMAT_MS_W'(`MMAT_VOL_MS);
    endcase
  endfunction

  logic pinS1, pinS2, pinPrev, stopS1, stopS2, stopSeen, reqS1, reqS2, reqSeen;
  logic next_pinS1, next_pinS2, next_pinPrev, next_stopS1, next_stopS2, next_stopSeen;
  logic next_reqS1, next_reqS2, next_reqSeen;
  logic [`MMAT_CNT_W-1:0] lowCount, next_lowCount, msCount, next_msCount;
  logic resetArmed, releaseEvt, stopEvt, reqEvt;
  logic [`MMAT_MS_W-1:0] fgLimit;

  // A reset pulse counts once it has stayed low for the minimum time.
  assign resetArmed = (lowCount >= `MMAT_CNT_W'(`MMAT_RESET_MIN_CYC));
  assign releaseEvt = resetArmed && pinS2 && !pinPrev;
  assign stopEvt = stopS2 ^ stopSeen;
  assign reqEvt = reqS2 ^ reqSeen;
  assign msTick = (msCount == `MMAT_CNT_W'(MS_CYCLES - 1));
  // Advertised busy limit is clamped so the hold-off never exceeds the ceiling.
  assign fgLimit = !fgLimitAdvertised ? `MMAT_MS_W'(FG_DEFAULT_MS) :
                   (fgBusyLimitMs > `MMAT_MS_W'(`MMAT_FG_MAX_MS)) ? `MMAT_MS_W'(`MMAT_FG_MAX_MS) :
                   fgBusyLimitMs;

  // Synchronisers, reset pulse width counter and millisecond prescaler.
  always_comb begin
    next_pinS1 = hostReset_n;
    next_pinS2 = pinS1;
    next_pinPrev = pinS2;
    next_stopS1 = stopToggle;
    next_stopS2 = stopS1;
    next_stopSeen = stopS2;
    next_reqS1 = readReqToggle;
    next_reqS2 = reqS1;
    next_reqSeen = reqS2;
    next_msCount = msTick ? `MMAT_CNT_W'(0) : msCount + `MMAT_CNT_W'(1);
    if (pinS2) begin
      next_lowCount = `MMAT_CNT_W'(0);
    end else if (!resetArmed) begin
      next_lowCount = lowCount + `MMAT_CNT_W'(1);
    end else begin
      next_lowCount = lowCount;
    end
    if (releaseEvt) begin
      next_lowCount = `MMAT_CNT_W'(0);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinS1 <= 1'b1;
      pinS2 <= 1'b1;
      pinPrev <= 1'b1;
      stopS1 <= 1'b0;
      stopS2 <= 1'b0;
      stopSeen <= 1'b0;
      reqS1 <= 1'b0;
      reqS2 <= 1'b0;
      reqSeen <= 1'b0;
      lowCount <= `MMAT_CNT_W'(0);
      msCount <= `MMAT_CNT_W'(0);
    end else begin
      pinS1 <= next_pinS1;
      pinS2 <= next_pinS2;
      pinPrev <= next_pinPrev;
      stopS1 <= next_stopS1;
      stopS2 <= next_stopS2;
      stopSeen <= next_stopSeen;
      reqS1 <= next_reqS1;
      reqS2 <= next_reqS2;
      reqSeen <= next_reqSeen;
      lowCount <= next_lowCount;
      msCount <= next_msCount;
    end
  end

  mmat_pkg::mmat_state_t state, next_state;
  logic [`MMAT_MS_W-1:0] holdMs, next_holdMs, holdLimit, next_holdLimit;
  logic next_holdOffActive, next_opStart, next_coreResetReq, next_lowPowerState;
  logic next_initFault, next_holdOffFault, ackDue, next_ackDue, next_stopAckToggle;
  logic [`MMAT_KIND_W-1:0] next_opKind;
  logic holdKind;

  // Diagnostics selector and freeze requests update registers but never hold access off.
  assign holdKind = (stopKind != mmat_pkg::MMAT_KIND_DIAG) && (stopKind != mmat_pkg::MMAT_KIND_FREEZE) &&
                    (stopKind != mmat_pkg::MMAT_KIND_NONE);

  // Manageability and hold-off supervisor.
  always_comb begin
    next_state = state;
    next_holdMs = msTick ? incSat(holdMs) : holdMs;
    next_holdLimit = holdLimit;
    next_holdOffActive = holdOffActive;
    next_opStart = 1'b0;
    next_opKind = opKind;
    next_coreResetReq = releaseEvt;
    next_lowPowerState = lowPowerExit ? 1'b0 : lowPowerState;
    next_initFault = initFault;
    next_holdOffFault = holdOffFault;
    // The ack toggle lags the hold-off level by a cycle so the link never sees the ack first.
    next_ackDue = stopEvt;
    next_stopAckToggle = stopAckToggle ^ ackDue;
    case (state)
      mmat_pkg::MMAT_ST_INIT: begin
        next_holdOffActive = 1'b1;
        if (coreReady) begin
          next_state = mmat_pkg::MMAT_ST_IDLE;
          next_holdOffActive = 1'b0;
        end else if (holdMs >= `MMAT_MS_W'(`MMAT_INIT_MAX_MS)) begin
          next_initFault = 1'b1; // Overrun is flagged and access opened anyway.
          next_state = mmat_pkg::MMAT_ST_IDLE;
          next_holdOffActive = 1'b0;
        end
      end
      mmat_pkg::MMAT_ST_IDLE: begin
        if (stopEvt && holdKind) begin
          next_state = mmat_pkg::MMAT_ST_HOLD;
          next_holdOffActive = 1'b1;
          next_holdMs = `MMAT_MS_W'(0);
          next_holdLimit = holdLimitFor(stopKind, fgLimit);
          next_opStart = 1'b1;
          next_opKind = stopKind;
        end
      end
      mmat_pkg::MMAT_ST_HOLD: begin
        if (opDone) begin
          next_state = mmat_pkg::MMAT_ST_IDLE;
          next_holdOffActive = 1'b0; // Written value readable from here.
        end else if (holdMs >= holdLimit) begin
          next_holdOffFault = 1'b1;
          next_state = mmat_pkg::MMAT_ST_IDLE;
          next_holdOffActive = 1'b0;
        end
      end
      default: begin
        next_state = mmat_pkg::MMAT_ST_INIT;
        next_holdOffActive = 1'b1;
      end
    endcase
    // A held reset pin keeps restarting the timer, so it counts from the latest release.
    if (resetArmed) begin
      next_state = mmat_pkg::MMAT_ST_INIT;
      next_holdOffActive = 1'b1;
      next_holdMs = `MMAT_MS_W'(0);
      next_lowPowerState = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= mmat_pkg::MMAT_ST_INIT;
      holdMs <= `MMAT_MS_W'(0);
      holdLimit <= `MMAT_MS_W'(`MMAT_VOL_MS);
      holdOffActive <= 1'b1;
      opStart <= 1'b0;
      opKind <= mmat_pkg::MMAT_KIND_NONE;
      coreResetReq <= 1'b0;
      lowPowerState <= 1'b1;
      initFault <= 1'b0;
      holdOffFault <= 1'b0;
      ackDue <= 1'b0;
      stopAckToggle <= 1'b0;
    end else begin
      state <= next_state;
      holdMs <= next_holdMs;
      holdLimit <= next_holdLimit;
      holdOffActive <= next_holdOffActive;
      opStart <= next_opStart;
      opKind <= next_opKind;
      coreResetReq <= next_coreResetReq;
      lowPowerState <= next_lowPowerState;
      initFault <= next_initFault;
      holdOffFault <= next_holdOffFault;
      ackDue <= next_ackDue;
      stopAckToggle <= next_stopAckToggle;
    end
  end

  logic depBusy, next_depBusy, next_depStart, next_depFault;
  logic readBusy, next_readBusy, next_readReq, next_readDoneToggle, next_readFault;
  logic [`MMAT_KIND_W-1:0] next_depKind;
  logic [`MMAT_MS_W-1:0] depMs, next_depMs;
  logic [`MMAT_CNT_W-1:0] readCyc, next_readCyc;

  // Dependent-register latency watch and read fetch with stretch limit.
  always_comb begin
    next_depBusy = depBusy;
    next_depStart = 1'b0;
    next_depKind = depKind;
    next_depFault = depFault;
    next_depMs = msTick ? incSat(depMs) : depMs;
    next_readBusy = readBusy;
    next_readReq = 1'b0;
    next_readDoneToggle = readDoneToggle;
    next_readFault = readFault;
    next_readCyc = readCyc + `MMAT_CNT_W'(1);
    if (depBusy && depDone) begin
      next_depBusy = 1'b0;
    end else if (depBusy && depMs >= `MMAT_MS_W'(`MMAT_DEP_MS)) begin
      next_depFault = 1'b1;
      next_depBusy = 1'b0;
    end
    if (stopEvt && !holdKind && stopKind != mmat_pkg::MMAT_KIND_NONE) begin
      next_depBusy = 1'b1; // Latency starts at the causing STOP.
      next_depStart = 1'b1;
      next_depKind = stopKind;
      next_depMs = `MMAT_MS_W'(0);
    end
    if (reqEvt) begin
      next_readBusy = 1'b1;
      next_readReq = 1'b1;
      next_readCyc = `MMAT_CNT_W'(0);
    end else if (readBusy && readDone) begin
      next_readBusy = 1'b0;
      next_readDoneToggle = ~readDoneToggle;
    end else if (readBusy && readCyc >= `MMAT_CNT_W'(READ_VAR_CYCLES - 1)) begin
      next_readFault = 1'b1; // Stretch is released rather than run past the limit.
      next_readBusy = 1'b0;
      next_readDoneToggle = ~readDoneToggle;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      depBusy <= 1'b0;
      depStart <= 1'b0;
      depKind <= mmat_pkg::MMAT_KIND_NONE;
      depFault <= 1'b0;
      depMs <= `MMAT_MS_W'(0);
      readBusy <= 1'b0;
      readReq <= 1'b0;
      readDoneToggle <= 1'b0;
      readFault <= 1'b0;
      readCyc <= `MMAT_CNT_W'(0);
    end else begin
      depBusy <= next_depBusy;
      depStart <= next_depStart;
      depKind <= next_depKind;
      depFault <= next_depFault;
      depMs <= next_depMs;
      readBusy <= next_readBusy;
      readReq <= next_readReq;
      readDoneToggle <= next_readDoneToggle;
      readFault <= next_readFault;
      readCyc <= next_readCyc;
    end
  end

endmodule
